//--- logic/bdsb_top.sv
// Background debug status/control and breakpoint block, top level
`timescale 1ns/1ps
`default_nettype none
module bdsb_top #(
  parameter int unsigned AW = bdsb_pkg::ADDR_W // Breakpoint width
) (
  input  wire logic            CLOCK,
  input  wire logic            RSTN,
  input  wire bdsb_pkg::bdsb_cmd_t CMD,
  input  wire logic            CMD_VALID,
  input  wire logic [15:0]     CMD_WDATA,
  input  wire logic            MEM_CMD_ACTIVE,
  input  wire logic            CPU_WAIT_STOP,
  input  wire logic            CPU_ENTER_BKGD,
  input  wire logic            CPU_RESUME,
  input  wire logic [AW-1:0]   CPU_ADDR,
  input  wire logic            CPU_FETCH,
  input  wire logic            TAG_AT_QUEUE_END,
  input  wire logic            INSN_BOUNDARY,
  output logic [15:0]          CMD_RDATA,
  output logic                 CMD_RVALID,
  output logic                 CMD_BLOCKED,
  output logic                 BKGD_REQ,
  output logic                 SOFT_INT_REQ,
  output logic                 TAG_OPCODE,
  output logic                 WAKE_TO_BKGD,
  output logic                 COMM_CLK_SEL
);
  import bdsb_pkg::*;

  logic          active_r;        // CPU in active background mode
  logic          wait_r;          // Wait/stop status
  logic          wfail_r;         // Wait/stop failure flag
  logic          force_pend_r;    // Force breakpoint pending
  logic [7:0]    ctrl_q;          // Control bits view
  logic [7:0]    stat_rd;         // Status/control read image
  logic [AW-1:0] bkpt_q;          // Match address
  logic          hit;             // Raw address match
  logic          ctrl_wr;         // Control write strobe
  logic          bkpt_wr;         // Breakpoint write strobe
  logic          cmd_ok;          // Command allowed to act
  logic          brk_fire;        // Breakpoint taken this cycle
  bdsb_brk_t     brk_kind;        // Kind of request

  // Commands other than background are blocked in wait/stop
  assign cmd_ok      = CMD_VALID && (!CPU_WAIT_STOP || CMD == CMD_BACKGROUND);
  assign CMD_BLOCKED = CMD_VALID && !cmd_ok;
  // Registers written only by the dedicated serial commands
  assign ctrl_wr     = cmd_ok && CMD == CMD_WRITE_CTRL;
  assign bkpt_wr     = cmd_ok && CMD == CMD_WRITE_BRK;

  // Status/control register
  bdsb_ctrl_reg u_ctrl (
    .clk          (CLOCK),
    .rst_n        (RSTN),
    .wr_en        (ctrl_wr),
    .wr_data      (CMD_WDATA[7:0]),
    .cpu_active   (active_r),
    .wait_status  (wait_r),
    .wfail_status (wfail_r),
    .ctrl_q       (ctrl_q),
    .read_val     (stat_rd)
  );

  // Breakpoint register and comparator
  bdsb_bkpt_match #(.AW(AW)) u_bkpt (
    .clk            (CLOCK),
    .rst_n          (RSTN),
    .wr_en          (bkpt_wr),
    .wr_data        (CMD_WDATA[AW-1:0]),
    .cpu_addr       (CPU_ADDR),
    .cpu_addr_valid (!active_r),
    .bkpt_q         (bkpt_q),
    .hit            (hit)
  );

  assign COMM_CLK_SEL = ctrl_q[BIT_CLKSEL];

  // Classify match; disabled breakpoint ignores select and address
  always_comb begin
    brk_kind = BRK_NONE;
    if (ctrl_q[BIT_BKPT_EN] && hit) begin
      if (ctrl_q[BIT_FORCE]) begin
        brk_kind = BRK_FORCE;
      end else if (CPU_FETCH) begin
        brk_kind = BRK_TAG;
      end
    end
  end

  // Tag goes with the fetched opcode into the queue
  assign TAG_OPCODE = (brk_kind == BRK_TAG);

  // Force request held until next instruction boundary
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      force_pend_r <= 1'b0;
    end else if (INSN_BOUNDARY || !ctrl_q[BIT_BKPT_EN]) begin
      force_pend_r <= 1'b0;
    end else if (brk_kind == BRK_FORCE) begin
      force_pend_r <= 1'b1;
    end
  end

  // Breakpoint fires at boundary (force) or when tag is executed
  assign brk_fire = ctrl_q[BIT_BKPT_EN] &&
                    ((force_pend_r && INSN_BOUNDARY) || TAG_AT_QUEUE_END);
  assign BKGD_REQ = (brk_fire && ctrl_q[BIT_PERMIT]) ||
                    (cmd_ok && CMD == CMD_BACKGROUND && ctrl_q[BIT_PERMIT]);
  assign SOFT_INT_REQ = brk_fire && !ctrl_q[BIT_PERMIT];
  // Background command wakes the CPU from wait/stop when the permit bit is set
  assign WAKE_TO_BKGD = cmd_ok && CMD == CMD_BACKGROUND && CPU_WAIT_STOP
                        && ctrl_q[BIT_PERMIT];

  // Active background mode tracking
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      active_r <= 1'b0;
    end else if (CPU_ENTER_BKGD) begin
      active_r <= 1'b1;
    end else if (CPU_RESUME) begin
      active_r <= 1'b0;
    end
  end

  // Wait/stop status, kept through a wakeup into active mode
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wait_r <= 1'b0;
    end else if (CPU_WAIT_STOP) begin
      wait_r <= 1'b1;
    end else if (CPU_RESUME || (!active_r && !CPU_ENTER_BKGD)) begin
      wait_r <= 1'b0;
    end
  end

  // Failure flag: memory command active in any wait/stop cycle; set wins
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wfail_r <= 1'b0;
    end else if (MEM_CMD_ACTIVE && CPU_WAIT_STOP) begin
      wfail_r <= 1'b1;
    end else if (CPU_RESUME) begin
      wfail_r <= 1'b0; // Cleared on return to user code
    end
  end

  // Read answers, registered
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      CMD_RDATA  <= 16'h0000;
      CMD_RVALID <= 1'b0;
    end else begin
      CMD_RVALID <= cmd_ok && (CMD == CMD_READ_STAT || CMD == CMD_READ_BRK);
      if (cmd_ok && CMD == CMD_READ_STAT) begin
        CMD_RDATA <= {8'h00, stat_rd};
      end else if (cmd_ok && CMD == CMD_READ_BRK) begin
        CMD_RDATA <= 16'(bkpt_q);
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/bdsb_pkg.sv
// Package for the background debug status and breakpoint block
package bdsb_pkg;
  // Status/control bit positions
  localparam int unsigned BIT_PERMIT   = 7;     // Background permit
  localparam int unsigned BIT_ACTIVE   = 6;     // Active background status
  localparam int unsigned BIT_BKPT_EN  = 5;     // Breakpoint enable
  localparam int unsigned BIT_FORCE    = 4;     // Force/tag select
  localparam int unsigned BIT_CLKSEL   = 3;     // Comm clock select
  localparam int unsigned BIT_WAIT     = 2;     // Wait/stop status
  localparam int unsigned BIT_WFAIL    = 1;     // Wait/stop failure
  localparam int unsigned BIT_SAF      = 0;     // Slow access failure
  // Widths
  localparam int unsigned CTRL_W       = 8;     // Status/control width
  localparam int unsigned ADDR_W       = 16;    // Breakpoint address width
  // Reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00; // Control bits reset
  localparam logic [15:0] BKPT_RST     = 16'h0000; // Match address reset
  // Serial command codes seen on the command port
  typedef enum logic [4:0] {
    CMD_NONE       = 5'h00,                     // Idle
    CMD_READ_STAT  = 5'h01,                     // Read status/control
    CMD_WRITE_CTRL = 5'h02,                     // Write status/control
    CMD_READ_BRK   = 5'h04,                     // Read breakpoint
    CMD_WRITE_BRK  = 5'h08,                     // Write breakpoint
    CMD_BACKGROUND = 5'h10                      // Background command
  } bdsb_cmd_t;
  // Breakpoint request kind to the CPU
  typedef enum logic [2:0] {
    BRK_NONE  = 3'h1,                           // No request
    BRK_FORCE = 3'h2,                           // Force at instruction end
    BRK_TAG   = 3'h4                            // Tag fetched opcode
  } bdsb_brk_t;
endpackage

//--- logic/bdsb_ctrl_reg.sv
// Status/control register: writable control bits and live status bits
`timescale 1ns/1ps
`default_nettype none
module bdsb_ctrl_reg (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  input  wire logic        cpu_active,
  input  wire logic        wait_status,
  input  wire logic        wfail_status,
  output logic [7:0]       ctrl_q,
  output logic [7:0]       read_val
);
  import bdsb_pkg::*;

  logic permit_r;                     // Background permit
  logic bkpt_en_r;                    // Breakpoint enable
  logic force_r;                      // Force/tag select
  logic clksel_r;                     // Comm clock select

  // Permit: sticky once set, writes blocked in active mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      permit_r <= CTRL_RST[BIT_PERMIT];
    end else if (wr_en && !cpu_active && wr_data[BIT_PERMIT]) begin
      permit_r <= 1'b1;
    end
  end

  // Other control bits, writable any time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bkpt_en_r <= CTRL_RST[BIT_BKPT_EN];
      force_r   <= CTRL_RST[BIT_FORCE];
      clksel_r  <= CTRL_RST[BIT_CLKSEL];
    end else if (wr_en) begin
      bkpt_en_r <= wr_data[BIT_BKPT_EN];
      force_r   <= wr_data[BIT_FORCE];
      clksel_r  <= wr_data[BIT_CLKSEL];
    end
  end

  // Compose control view and read image; status bits never written
  always_comb begin
    ctrl_q              = 8'h00;
    ctrl_q[BIT_PERMIT]  = permit_r;
    ctrl_q[BIT_BKPT_EN] = bkpt_en_r;
    ctrl_q[BIT_FORCE]   = force_r;
    ctrl_q[BIT_CLKSEL]  = clksel_r;
    read_val            = ctrl_q;
    read_val[BIT_ACTIVE] = cpu_active;
    read_val[BIT_WAIT]   = wait_status;
    read_val[BIT_WFAIL]  = wfail_status;
    read_val[BIT_SAF]    = 1'b0;
  end
endmodule
`default_nettype wire

//--- logic/bdsb_bkpt_match.sv
// Breakpoint address register and comparator
`timescale 1ns/1ps
`default_nettype none
module bdsb_bkpt_match #(
  parameter int unsigned AW = 16      // Match address width
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_data,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic          cpu_addr_valid,
  output logic [AW-1:0]      bkpt_q,
  output logic               hit
);
  import bdsb_pkg::*;

  // Match address storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bkpt_q <= BKPT_RST[AW-1:0];
    end else if (wr_en) begin
      bkpt_q <= wr_data;
    end
  end

  // Address compare
  assign hit = cpu_addr_valid && (cpu_addr == bkpt_q);
endmodule
`default_nettype wire

//--- verif/bdsb_cpu_model.sv
// CPU side model that answers background entry and resume
`timescale 1ns/1ps
`default_nettype none
module bdsb_cpu_model (
  input  wire logic CLOCK,
  input  wire logic RSTN,
  input  wire logic BKGD_REQ,
  input  wire logic WAKE_TO_BKGD,
  input  wire logic resume_req,
  input  wire logic halt_req,
  output logic      CPU_ENTER_BKGD,
  output logic      CPU_RESUME
);
  logic in_bkgd_r; // Halted in background
  // Enter a cycle after a request, leave when asked
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      in_bkgd_r      <= 1'b0;
      CPU_ENTER_BKGD <= 1'b0;
      CPU_RESUME     <= 1'b0;
    end else begin
      // Halt request models an entry that needs no permit
      CPU_ENTER_BKGD <= (BKGD_REQ | WAKE_TO_BKGD | halt_req) & ~in_bkgd_r;
      CPU_RESUME     <= resume_req & in_bkgd_r;
      if (CPU_ENTER_BKGD) in_bkgd_r <= 1'b1;
      else if (CPU_RESUME) in_bkgd_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verif/bdsb_top_properties.sv
// Port checker for the debug status and breakpoint block
`timescale 1ns/1ps
`default_nettype none
module bdsb_top_props (
  input wire logic               CLOCK, RSTN, CMD_VALID, CPU_WAIT_STOP, CPU_FETCH, CMD_RVALID, CMD_BLOCKED,
  input wire logic               BKGD_REQ, SOFT_INT_REQ, TAG_OPCODE, WAKE_TO_BKGD, COMM_CLK_SEL,
  input wire bdsb_pkg::bdsb_cmd_t CMD,
  input wire logic [15:0]        CMD_RDATA
);
  import bdsb_pkg::*;
  logic ls_r; // Last accepted command read status
  logic pm_r; // Permit once seen set
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // Track status reads and the permit bit seen
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ls_r <= 1'b0;
      pm_r <= 1'b0;
    end else begin
      ls_r <= CMD_VALID && CMD == CMD_READ_STAT && !CPU_WAIT_STOP;
      if (CMD_RVALID && ls_r && CMD_RDATA[7]) pm_r <= 1'b1;
    end
  end
  property p_rv; CMD_VALID && !CPU_WAIT_STOP && (CMD == CMD_READ_STAT || CMD == CMD_READ_BRK) |=> CMD_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_blk; CMD_VALID && CPU_WAIT_STOP && CMD != CMD_BACKGROUND |-> CMD_BLOCKED; endproperty
  a_blk: assert property (p_blk) else $error("command not refused");
  property p_saf; CMD_RVALID && ls_r |-> !CMD_RDATA[0]; endproperty
  a_saf: assert property (p_saf) else $error("slow flag set");
  property p_ck; CMD_RVALID && ls_r |-> CMD_RDATA[3] == COMM_CLK_SEL; endproperty
  a_ck: assert property (p_ck) else $error("clock select mismatch");
  property p_prm; CMD_RVALID && ls_r && pm_r |-> CMD_RDATA[7]; endproperty
  a_prm: assert property (p_prm) else $error("permit cleared");
  // Interrupt fallback only while no read has shown the permit set
  property p_soft; SOFT_INT_REQ |-> !BKGD_REQ && !pm_r; endproperty
  a_soft: assert property (p_soft) else $error("interrupt fallback with permit");
  property p_tag; TAG_OPCODE |-> CPU_FETCH; endproperty
  a_tag: assert property (p_tag) else $error("tag without fetch");
  property p_wk; WAKE_TO_BKGD |-> CMD_VALID && CMD == CMD_BACKGROUND && CPU_WAIT_STOP; endproperty
  a_wk: assert property (p_wk) else $error("stray wakeup");
  c_soft: cover property (SOFT_INT_REQ);
  c_wk: cover property (WAKE_TO_BKGD);
  c_tag: cover property (TAG_OPCODE);
endmodule
bind bdsb_top bdsb_top_props u_props (.CLOCK, .RSTN, .CMD_VALID, .CPU_WAIT_STOP, .CPU_FETCH, .CMD_RVALID,
  .CMD_BLOCKED, .BKGD_REQ, .SOFT_INT_REQ, .TAG_OPCODE, .WAKE_TO_BKGD, .COMM_CLK_SEL, .CMD, .CMD_RDATA);
`default_nettype wire

//--- verif/bdsb_top_bench.sv
// Self-checking bench for the debug status and breakpoint block
`timescale 1ns/1ps
`default_nettype none
module bdsb_top_bench;
  import bdsb_pkg::*;
  logic CLOCK = 0, RSTN = 0, CMD_VALID = 0, MEM_CMD_ACTIVE = 0, CPU_WAIT_STOP = 0, CPU_FETCH = 0;
  logic TAG_AT_QUEUE_END = 0, INSN_BOUNDARY = 0, resume_req = 0, halt_req = 0, CPU_ENTER_BKGD, CPU_RESUME;
  logic CMD_RVALID, CMD_BLOCKED, BKGD_REQ, SOFT_INT_REQ, TAG_OPCODE, WAKE_TO_BKGD, COMM_CLK_SEL;
  logic pm = 0, ac = 0, en = 0, ft = 0, ck = 0, wt = 0, wf = 0; // Expected status bits
  logic [15:0] CMD_WDATA = 0, CPU_ADDR = 0, CMD_RDATA, bk;
  logic [15:0] q[$]; // Expected read data
  bdsb_cmd_t CMD = CMD_NONE;
  int errors = 0, n_compared = 0;
  bdsb_top dut (.CLOCK, .RSTN, .CMD, .CMD_VALID, .CMD_WDATA, .MEM_CMD_ACTIVE, .CPU_WAIT_STOP, .CPU_ENTER_BKGD,
    .CPU_RESUME, .CPU_ADDR, .CPU_FETCH, .TAG_AT_QUEUE_END, .INSN_BOUNDARY, .CMD_RDATA, .CMD_RVALID, .CMD_BLOCKED,
    .BKGD_REQ, .SOFT_INT_REQ, .TAG_OPCODE, .WAKE_TO_BKGD, .COMM_CLK_SEL);
  bdsb_cpu_model cpu (.CLOCK, .RSTN, .BKGD_REQ, .WAKE_TO_BKGD, .resume_req, .halt_req, .CPU_ENTER_BKGD,
    .CPU_RESUME);
  always #25 CLOCK = ~CLOCK;
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [15:0] st(); return {8'h00, pm, ac, en, ft, ck, wt, wf, 1'b0}; endfunction
  function automatic logic [15:0] nx(logic [15:0] s); return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]}; endfunction
  // Read answers taken in order
  always @(posedge CLOCK) if (CMD_RVALID === 1'b1) chk("rdata", q.pop_front(), CMD_RDATA);
  // One command; refusal and wakeup seen in its cycle
  task automatic cmd(bdsb_cmd_t c, logic [15:0] d);
    CMD <= c;
    CMD_VALID <= 1'b1;
    CMD_WDATA <= d;
    #1 chk("blocked", 16'(CPU_WAIT_STOP && c != CMD_BACKGROUND), 16'(CMD_BLOCKED));
    chk("wake", 16'(CPU_WAIT_STOP && c == CMD_BACKGROUND && pm), 16'(WAKE_TO_BKGD));
    @(posedge CLOCK) CMD_VALID <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(bdsb_cmd_t c, logic [15:0] e);
    q.push_back(e);
    cmd(c, 16'h0000);
  endtask
  task automatic wc(logic [7:0] d);
    pm = pm | (d[7] & ~ac);
    {en, ft, ck} = d[5:3];
    cmd(CMD_WRITE_CTRL, {8'h00, d});
  endtask
  // Address match, then an instruction boundary
  task automatic brk(logic es, logic eb);
    CPU_ADDR <= bk;
    @(posedge CLOCK) INSN_BOUNDARY <= 1'b1;
    #1 chk("soft_int", 16'(es), 16'(SOFT_INT_REQ));
    chk("bkgd", 16'(eb), 16'(BKGD_REQ));
    @(posedge CLOCK) INSN_BOUNDARY <= 1'b0;
    CPU_ADDR <= ~bk;
  endtask
  task automatic enter;
    repeat (3) @(posedge CLOCK);
    ac = 1;
  endtask
  task automatic leave;
    resume_req <= 1'b1;
    @(posedge CLOCK) resume_req <= 1'b0;
    repeat (3) @(posedge CLOCK);
    {ac, wt, wf} = 3'b000;
  endtask
  task automatic rst;
    RSTN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RSTN <= 1'b1;
    {pm, ac, en, ft, ck, wt, wf} = 7'h00;
  endtask
  // Watchdog
  initial begin
    #100000;
    errors++;
    conclude;
  end
  initial begin
    rst;
    rd(CMD_READ_STAT, 16'h0000);
    rd(CMD_READ_BRK, 16'h0000);
    chk("clksel", 16'h0000, 16'(COMM_CLK_SEL));
    wc(8'h7F);
    rd(CMD_READ_STAT, st());
    bk = nx(16'h000D);
    cmd(CMD_WRITE_BRK, bk);
    rd(CMD_READ_BRK, bk);
    chk("clksel", 16'h0001, 16'(COMM_CLK_SEL));
    $display("test 1 done");
    wc(8'h10);
    brk(1'b0, 1'b0);
    wc(8'h30);
    brk(1'b1, 1'b0);
    wc(8'hB0);
    brk(1'b0, 1'b1);
    enter;
    rd(CMD_READ_STAT, st());
    // New match address loaded while halted
    bk = nx(bk);
    cmd(CMD_WRITE_BRK, bk);
    rd(CMD_READ_BRK, bk);
    wc(8'h08);
    rd(CMD_READ_STAT, st());
    leave;
    rd(CMD_READ_STAT, st());
    $display("test 2 done");
    wc(8'h20);
    CPU_ADDR <= bk;
    CPU_FETCH <= 1'b1;
    #1 chk("tag", 16'h0001, 16'(TAG_OPCODE));
    @(posedge CLOCK) CPU_FETCH <= 1'b0;
    CPU_ADDR <= ~bk;
    TAG_AT_QUEUE_END <= 1'b1;
    #1 chk("bkgd", 16'h0001, 16'(BKGD_REQ));
    @(posedge CLOCK) TAG_AT_QUEUE_END <= 1'b0;
    enter;
    leave;
    CPU_WAIT_STOP <= 1'b1;
    wt = 1;
    cmd(CMD_READ_STAT, 16'h0000);
    MEM_CMD_ACTIVE <= 1'b1;
    @(posedge CLOCK) MEM_CMD_ACTIVE <= 1'b0;
    wf = 1;
    cmd(CMD_BACKGROUND, 16'h0000);
    enter;
    CPU_WAIT_STOP <= 1'b0;
    rd(CMD_READ_STAT, st());
    rd(CMD_READ_BRK, bk);
    leave;
    rd(CMD_READ_STAT, st());
    $display("test 3 done");
    rst;
    rd(CMD_READ_STAT, 16'h0000);
    rd(CMD_READ_BRK, 16'h0000);
    // Halted without permit: permit write must be ignored
    halt_req <= 1'b1;
    @(posedge CLOCK) halt_req <= 1'b0;
    enter;
    wc(8'h80);
    rd(CMD_READ_STAT, st());
    leave;
    $display("test 4 done");
    conclude;
  end
endmodule
`default_nettype wire
